// >>> csr_pkg.sv
// Contract
// - tile-colour register is 32-bit read-only; writes leave it unchanged
// - colours read as ascii initials: red 52h, green 47h, blue 42h, mono 59h
// - tile fields: pixel (0,0), (0,1), (1,0), (1,1) in ascending bit groups
// - any non-raw output pixel format reports all four positions as 59h
// - flash reads all ones wherever nothing has been written yet
// - software stages any amount of data; a control write commits it to flash
// - accessing any other control register also commits modified staged data; here only tile-register accesses and data writes to another page commit it
// - control bit 0 reads 1 when the flash feature is present, else 0
// - control bit 6 reads 0 while page buffer is dirty, 1 when clean
// - writing 1 to control bit 6 writes the page to flash; 0 does nothing
// - flash data register is one 32-bit field: offset of staged data; here it holds the data word at that offset, not the offset
package csr_pkg;

   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [15:0] ADDR_TILE = 16'h1040;
   localparam logic [15:0] ADDR_CTRL = 16'h1240;
   localparam logic [15:0] ADDR_OFFSET = 16'h1244;
   localparam logic [15:0] ADDR_DATA = 16'h1248;

   // ----------------------------------------
   // field positions, as lsb-based indices
   // ----------------------------------------
   localparam int TILE_P00_LSB = 24;
   localparam int TILE_P01_LSB = 16;
   localparam int TILE_P10_LSB = 8;
   localparam int TILE_P11_LSB = 0;
   localparam int PRESENCE_BIT = 31;
   localparam int CLEAN_BIT = 25;
   localparam int PAGE_SIZE_LSB = 12;
   localparam int NUM_PAGES_LSB = 0;
   localparam int CODE_W = 12;

   // ----------------------------------------
   // codes and reset values
   // ----------------------------------------
   localparam logic [7:0] ASCII_RED = 8'h52;
   localparam logic [7:0] ASCII_GREEN = 8'h47;
   localparam logic [7:0] ASCII_BLUE = 8'h42;
   localparam logic [7:0] ASCII_MONO = 8'h59;
   localparam int PAGE_SIZE_CODE_RST = 8;
   localparam int NUM_PAGES_CODE_RST = 11;
   localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
   localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
   localparam logic [31:0] OFFSET_STEP = 32'h0000_0004;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {tile_red, tile_green, tile_blue, tile_mono} tile_colour_t;

   typedef struct packed {
      tile_colour_t p00;
      tile_colour_t p01;
      tile_colour_t p10;
      tile_colour_t p11;
   } tile_pattern_t;

endpackage

// >>> bayer_map_and_flash_page_csrs.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
module bayer_map_and_flash_page_csrs #(
   parameter int ADDR_W = 16,
   parameter int PAGE_SIZE_CODE = csr_pkg::PAGE_SIZE_CODE_RST,
   parameter int NUM_PAGES_CODE = csr_pkg::NUM_PAGES_CODE_RST,
   parameter bit FLASH_PRESENT = 1'b1
)(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sensor side
   input wire logic raw_format,
   input wire csr_pkg::tile_pattern_t tile_pattern
);

   // ----------------------------------------
   // derived sizes
   // ----------------------------------------
   localparam int WORD_BITS = PAGE_SIZE_CODE - 2;
   localparam int PAGE_WORDS = 1 << WORD_BITS;
   localparam int FLASH_PAGES = 1 << NUM_PAGES_CODE;
   localparam int MEM_AW = NUM_PAGES_CODE + WORD_BITS;
   localparam int FLASH_WORDS = 1 << MEM_AW;
   localparam int OFF_TOP = PAGE_SIZE_CODE + NUM_PAGES_CODE - 1;

   // memory size is kept modest so the array stays simulable
   generate
      if (ADDR_W < 13 || ADDR_W > 32)
      begin : g_bad_addr
         $error("ADDR_W must be 13..32");
      end
      if (PAGE_SIZE_CODE < 3 || PAGE_SIZE_CODE > 12)
      begin : g_bad_page
         $error("PAGE_SIZE_CODE must be 3..12");
      end
      if (NUM_PAGES_CODE < 1 || MEM_AW > 22)
      begin : g_bad_count
         $error("NUM_PAGES_CODE out of range");
      end
   endgenerate

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] colour_code(input csr_pkg::tile_colour_t c);
      logic [7:0] r;
      r = csr_pkg::ASCII_MONO;
      case (c)
         csr_pkg::tile_red: r = csr_pkg::ASCII_RED;
         csr_pkg::tile_green: r = csr_pkg::ASCII_GREEN;
         csr_pkg::tile_blue: r = csr_pkg::ASCII_BLUE;
         default: r = csr_pkg::ASCII_MONO;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic {st_idle, st_commit} commit_state_t;

   commit_state_t state_r;
   commit_state_t state_nxt;
   logic idle_q_r;
   logic rd_loaded_r;
   logic [31:0] offset_r;
   logic [31:0] prdata_r;
   logic [NUM_PAGES_CODE-1:0] buf_page_r;
   logic [PAGE_WORDS-1:0] mask_r;
   logic [FLASH_PAGES-1:0] written_r;
   logic [WORD_BITS-1:0] cnt_r;
   logic [31:0] buf_mem [PAGE_WORDS];
   logic [31:0] flash_mem [FLASH_WORDS];

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   wire logic [ADDR_W-3:0] word_sel = paddr[ADDR_W-1:2];
   wire logic [ADDR_W-1:0] a_tile = ADDR_W'(csr_pkg::ADDR_TILE);
   wire logic [ADDR_W-1:0] a_ctrl = ADDR_W'(csr_pkg::ADDR_CTRL);
   wire logic [ADDR_W-1:0] a_offset = ADDR_W'(csr_pkg::ADDR_OFFSET);
   wire logic [ADDR_W-1:0] a_data = ADDR_W'(csr_pkg::ADDR_DATA);
   wire logic hit_tile = (word_sel == a_tile[ADDR_W-1:2]);
   wire logic hit_ctrl = (word_sel == a_ctrl[ADDR_W-1:2]);
   wire logic hit_offset = (word_sel == a_offset[ADDR_W-1:2]);
   wire logic hit_data = (word_sel == a_data[ADDR_W-1:2]);
   wire logic hit_any = hit_tile | hit_ctrl | hit_offset | hit_data;
   wire logic access = psel & penable;

   // ----------------------------------------
   // tile colour word
   // ----------------------------------------
   // first pixel lands in the top byte since bit 0 counts from the msb
   wire logic [31:0] tile_raw = {colour_code(tile_pattern.p00),
                                 colour_code(tile_pattern.p01),
                                 colour_code(tile_pattern.p10),
                                 colour_code(tile_pattern.p11)};
   wire logic [31:0] tile_mono_w = {4{csr_pkg::ASCII_MONO}};
   // built from pins alone, so no write can ever alter it
   wire logic [31:0] tile_word = raw_format ? tile_raw : tile_mono_w;

   // ----------------------------------------
   // flash window and page buffer view
   // ----------------------------------------
   wire logic [NUM_PAGES_CODE-1:0] off_page = offset_r[OFF_TOP:PAGE_SIZE_CODE];
   wire logic [WORD_BITS-1:0] off_word = offset_r[PAGE_SIZE_CODE-1:2];
   wire logic dirty = |mask_r;
   wire logic page_clash = dirty & (buf_page_r != off_page);
   wire logic staged_hit = dirty & ~page_clash & mask_r[off_word];
   // never-written pages read erased without touching the array
   wire logic [31:0] flash_word = written_r[off_page] ? flash_mem[{off_page, off_word}]
                                                      : csr_pkg::ERASED_WORD;
   wire logic [31:0] data_word = staged_hit ? buf_mem[off_word] : flash_word;

   // ----------------------------------------
   // control word
   // ----------------------------------------
   wire logic [csr_pkg::CODE_W-1:0] page_code = csr_pkg::CODE_W'(PAGE_SIZE_CODE);
   wire logic [csr_pkg::CODE_W-1:0] count_code = csr_pkg::CODE_W'(NUM_PAGES_CODE);
   logic [31:0] ctrl_word;

   always_comb
   begin
      ctrl_word = '0;
      ctrl_word[csr_pkg::PRESENCE_BIT] = FLASH_PRESENT;
      ctrl_word[csr_pkg::CLEAN_BIT] = ~dirty;
      ctrl_word[csr_pkg::PAGE_SIZE_LSB +: csr_pkg::CODE_W] = page_code;
      ctrl_word[csr_pkg::NUM_PAGES_LSB +: csr_pkg::CODE_W] = count_code;
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire logic [31:0] rdata_mux = hit_tile ? tile_word :
                                 hit_ctrl ? ctrl_word :
                                 hit_offset ? offset_r :
                                 hit_data ? data_word : '0;

   // ----------------------------------------
   // handshake
   // ----------------------------------------
   // one settled idle cycle before answering keeps prdata_r coherent after a commit
   wire logic idle = (state_r == st_idle);
   wire logic settled = idle & idle_q_r;
   wire logic clash_wr = hit_data & pwrite & page_clash;
   // a read answers only after prdata_r was loaded on an enabled edge of this transfer
   wire logic done = clk_en & access & settled & ~clash_wr & (pwrite | rd_loaded_r);
   wire logic wr_done = done & pwrite;

   assign pready = done;
   assign pslverr = done & ~hit_any;
   assign prdata = prdata_r;

   // ----------------------------------------
   // commit triggers
   // ----------------------------------------
   wire logic ctrl_commit = wr_done & hit_ctrl & pwdata[csr_pkg::CLEAN_BIT];
   wire logic other_commit = done & hit_tile;
   wire logic clash_commit = clk_en & access & settled & clash_wr;
   wire logic commit_start = dirty & (ctrl_commit | other_commit | clash_commit);
   wire logic commit_last = (state_r == st_commit) & (cnt_r == WORD_BITS'(PAGE_WORDS - 1));

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         st_idle:
         begin
            if (commit_start)
            begin
               state_nxt = st_commit;
            end
         end
         st_commit:
         begin
            if (commit_last)
            begin
               state_nxt = st_idle;
            end
         end
         default: state_nxt = st_idle;
      endcase
   end

   // ----------------------------------------
   // control flops
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= st_idle;
         idle_q_r <= 1'b0;
         cnt_r <= '0;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         idle_q_r <= idle;
         cnt_r <= (state_r == st_commit) ? cnt_r + 1'b1 : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= '0;
      end
      else if (clk_en && psel && !pwrite)
      begin
         prdata_r <= rdata_mux;
      end
   end

   // cleared on completion, so a setup frozen by clk_en cannot hand back stale data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_loaded_r <= 1'b0;
      end
      else if (clk_en)
      begin
         rd_loaded_r <= psel & ~pwrite & ~done;
      end
   end

   // writes to the tile and control words never reach any storage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         offset_r <= csr_pkg::OFFSET_RST;
      end
      else if (wr_done && hit_offset)
      begin
         offset_r <= merge(offset_r, pwdata, pstrb);
      end
      else if (wr_done && hit_data)
      begin
         offset_r <= offset_r + csr_pkg::OFFSET_STEP;
      end
   end

   // ----------------------------------------
   // page buffer bookkeeping
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_r <= '0;
         buf_page_r <= '0;
         written_r <= '0;
      end
      else if (clk_en)
      begin
         if (commit_last)
         begin
            mask_r <= '0;
            written_r[buf_page_r] <= 1'b1;
         end
         else if (wr_done && hit_data)
         begin
            mask_r[off_word] <= 1'b1;
            buf_page_r <= off_page;
         end
      end
   end

   always_ff @(posedge pclk)
   begin
      if (clk_en && wr_done && hit_data)
      begin
         buf_mem[off_word] <= merge(data_word, pwdata, pstrb);
      end
   end

   // ----------------------------------------
   // commit engine, one word per cycle
   // ----------------------------------------
   // a first commit fills untouched words with ones so the page stays erased-looking
   always_ff @(posedge pclk)
   begin
      if (clk_en && state_r == st_commit)
      begin
         if (mask_r[cnt_r])
         begin
            flash_mem[{buf_page_r, cnt_r}] <= buf_mem[cnt_r];
         end
         else if (!written_r[buf_page_r])
         begin
            flash_mem[{buf_page_r, cnt_r}] <= csr_pkg::ERASED_WORD;
         end
      end
   end

endmodule

// >>> csr_checker_props.sv
`timescale 1ns/1ns
module csr_checker #(
   parameter int ADDR_W = 16,
   parameter int PAGE_SIZE_CODE = 8,
   parameter int NUM_PAGES_CODE = 11,
   parameter bit FLASH_PRESENT = 1'b1
)(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // sensor side
   input wire logic raw_format,
   input wire csr_pkg::tile_pattern_t tile_pattern
);
   // ------------------------------------
   // shadow of dirty flag and offset
   // ------------------------------------
   logic dn, rt, rc, ro, wd, wc;
   logic dirty_r, dirty_nxt;
   logic [31:0] off_r, off_nxt, tile;
   function automatic logic [7:0] code(input logic [1:0] c);
      logic [31:0] t;
      t = {csr_pkg::ASCII_MONO, csr_pkg::ASCII_BLUE, csr_pkg::ASCII_GREEN, csr_pkg::ASCII_RED};
      return t[c*8+:8];
   endfunction
   assign dn = psel && penable && pready;
   assign rt = dn && !pwrite && paddr == csr_pkg::ADDR_TILE;
   assign rc = dn && !pwrite && paddr == csr_pkg::ADDR_CTRL;
   assign ro = dn && !pwrite && paddr == csr_pkg::ADDR_OFFSET;
   assign wd = dn && pwrite && paddr == csr_pkg::ADDR_DATA;
   assign wc = dn && pwrite && paddr == csr_pkg::ADDR_CTRL && pwdata[csr_pkg::CLEAN_BIT];
   // any tile access commits too, read or write
   assign dirty_nxt = wd || (dirty_r && !wc && !(dn && paddr == csr_pkg::ADDR_TILE));
   // bench always writes whole words, so strobes are not tracked
   assign off_nxt = (dn && pwrite && paddr == csr_pkg::ADDR_OFFSET) ? pwdata : off_r + (wd ? 32'h4 : 32'h0);
   assign tile = {code(tile_pattern.p00), code(tile_pattern.p01), code(tile_pattern.p10), code(tile_pattern.p11)};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dirty_r <= 1'b0;
         off_r <= 32'h0;
      end
      else
      begin
         dirty_r <= dirty_nxt;
         off_r <= off_nxt;
      end
   end
   // ------------------------------------
   // properties
   // ------------------------------------
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_tile_mono;
      rt && !raw_format |-> prdata == 32'h5959_5959;
   endproperty
   a_tile_mono: assert property (p_tile_mono) else $error("tile not mono");
   property p_tile_raw;
      rt && raw_format |-> prdata == tile;
   endproperty
   a_tile_raw: assert property (p_tile_raw) else $error("tile letters wrong");
   property p_presence;
      rc |-> prdata[csr_pkg::PRESENCE_BIT] == FLASH_PRESENT;
   endproperty
   a_presence: assert property (p_presence) else $error("presence wrong");
   property p_page_size;
      rc |-> prdata[23:12] == 12'(PAGE_SIZE_CODE);
   endproperty
   a_page_size: assert property (p_page_size) else $error("page size wrong");
   property p_num_pages;
      rc |-> prdata[11:0] == 12'(NUM_PAGES_CODE);
   endproperty
   a_num_pages: assert property (p_num_pages) else $error("page count wrong");
   property p_reserved;
      rc |-> prdata[30:26] == 5'h0 && !prdata[24];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
   property p_clean;
      rc |-> prdata[csr_pkg::CLEAN_BIT] == !dirty_r;
   endproperty
   a_clean: assert property (p_clean) else $error("clean bit wrong");
   property p_offset;
      ro |-> prdata == off_r;
   endproperty
   a_offset: assert property (p_offset) else $error("offset wrong");
endmodule

// >>> bayer_map_and_flash_page_csrs_test.sv
`timescale 1ns/1ns
module bayer_map_and_flash_page_csrs_test;
   // ------------------------------------
   // bench state, model and hookup
   // ------------------------------------
   localparam int PSC = 4;
   localparam int NPC = 3;
   localparam logic [15:0] A_T = csr_pkg::ADDR_TILE;
   localparam logic [15:0] A_C = csr_pkg::ADDR_CTRL;
   localparam logic [15:0] A_O = csr_pkg::ADDR_OFFSET;
   localparam logic [15:0] A_D = csr_pkg::ADDR_DATA;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, raw_format, err, dirty;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, off;
   logic [3:0] pstrb;
   csr_pkg::tile_pattern_t tile_pattern;
   logic [31:0] mem [int];
   int miscompares, comparisons;
   bayer_map_and_flash_page_csrs #(.PAGE_SIZE_CODE(PSC), .NUM_PAGES_CODE(NPC)) bayer_map_and_flash_page_csrs_i (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .raw_format(raw_format), .tile_pattern(tile_pattern));
   task automatic print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // one idle cycle first, so psel is never assigned twice in a step
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 300)
      begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         miscompares++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == A_D)
      begin
         mem[off] = d;
         off = off + 32'h4;
         dirty = 1'b1;
      end
      if (a == A_O)
         off = d;
      if (a == A_T || (a == A_C && d[csr_pkg::CLEAN_BIT]))
         dirty = 1'b0;
      check({31'h0, err}, 32'h0);
   endtask
   task automatic rd_chk(input logic [15:0] a);
      logic [31:0] e;
      logic [31:0] t;
      t = {csr_pkg::ASCII_MONO, csr_pkg::ASCII_BLUE, csr_pkg::ASCII_GREEN, csr_pkg::ASCII_RED};
      apb(1'b0, a, 32'h0);
      e = 32'h0;
      if (a == A_T)
         e = raw_format ? {t[tile_pattern.p00*8+:8], t[tile_pattern.p01*8+:8], t[tile_pattern.p10*8+:8],
            t[tile_pattern.p11*8+:8]} : 32'h5959_5959;
      if (a == A_C)
         e = {1'b1, 5'h0, !dirty, 1'b0, 12'(PSC), 12'(NPC)};
      if (a == A_O)
         e = off;
      if (a == A_D)
         e = mem.exists(off) ? mem[off] : 32'hffff_ffff;
      if (a == A_T)
         dirty = 1'b0;
      check(rd, e);
      check({31'h0, err}, {31'h0, !(a inside {A_T, A_C, A_O, A_D})});
   endtask
   // ------------------------------------
   // clock and scenarios
   // ------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, raw_format, dirty} = 6'h0;
      clk_en = 1'b1;
      pstrb = 4'hf;
      paddr = 16'h0;
      pwdata = 32'h0;
      tile_pattern = csr_pkg::tile_pattern_t'(8'h1b);
      seed = 32'd42857;
      off = 32'h0;
      miscompares = 0;
      comparisons = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(A_T);
      raw_format <= 1'b1;
      // every code lands in every tile position
      for (int i = 0; i < 5; i++)
      begin
         tile_pattern <= csr_pkg::tile_pattern_t'(i < 4 ? {2'(i), 2'(i + 1), 2'(i + 2), 2'(i + 3)} : 8'(xs()));
         rd_chk(A_T);
      end
      wr(A_T, xs());
      rd_chk(A_T);
      rd_chk(A_C);
      wr(A_C, 32'hfdff_ffff);
      rd_chk(A_C);
      rd_chk(A_D);
      wr(A_O, 32'h10);
      rd_chk(A_O);
      // six words cross a page edge, forcing a commit mid-stream
      repeat (6) wr(A_D, xs());
      rd_chk(A_O);
      rd_chk(A_C);
      wr(A_C, 32'h0);
      rd_chk(A_C);
      wr(A_C, 32'h0200_0000);
      rd_chk(A_C);
      for (int i = 0; i < 8; i++)
      begin
         wr(A_O, 32'h10 + 32'(i * 4));
         rd_chk(A_D);
      end
      wr(A_D, xs());
      rd_chk(A_C);
      rd_chk(A_T);
      rd_chk(A_C);
      wr(A_D, xs());
      wr(A_T, xs());
      rd_chk(A_C);
      // clock enable low across a read setup must stall it, not return stale data
      clk_en <= 1'b0;
      fork
         rd_chk(A_O);
         begin
            repeat (3) @(posedge pclk);
            clk_en <= 1'b1;
         end
      join
      rd_chk(16'h1300);
      raw_format <= 1'b0;
      rd_chk(A_T);
      print_verdict();
   end
endmodule
bind bayer_map_and_flash_page_csrs csr_checker #(.ADDR_W(ADDR_W), .PAGE_SIZE_CODE(PAGE_SIZE_CODE),
   .NUM_PAGES_CODE(NUM_PAGES_CODE), .FLASH_PRESENT(FLASH_PRESENT)) csr_checker_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .raw_format(raw_format), .tile_pattern(tile_pattern));
